//--- rtl/ees_pkg.sv
package ees_pkg;

	// Clock rate and internal write-cycle duration
	localparam int CLK_FREQ_HZ       = 50_000_000;
	localparam int WRITE_TIME_US     = 10_000;
	// Longest time, so the cycle count rounds down
	localparam int WRITE_CYCLE_COUNT = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

	// Array geometry
	localparam int MEM_ADDR_W = 18;
	localparam int MEM_BYTES  = 262144;
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_W     = 8;

	// Select byte layout
	localparam logic [2:0] SEL_FAMILY     = 3'h5;
	localparam int         SEL_FAMILY_LSB = 5;
	localparam int         SEL_ID_BIT     = 4;
	localparam int         SEL_STRAP_BIT  = 3;
	localparam int         SEL_A17_BIT    = 2;
	localparam int         SEL_RW_BIT     = 0;

	// Identification page lock command fields
	localparam int ID_LOCK_ADDR_BIT = 10;
	localparam int ID_LOCK_DATA_BIT = 1;

	// Bit counter value of the acknowledge slot
	localparam logic [3:0] ACK_SLOT  = 4'h8;
	localparam logic [3:0] LAST_DATA = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DEVSEL  = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA   = 3'b100,
		ST_RDATA   = 3'b101,
		ST_WRCYC   = 3'b110
	} ees_state_t;

endpackage : ees_pkg

//--- rtl/ees_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ees_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_reg <= '0;
			q_o      <= '0;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule : ees_sync
`default_nettype wire

//--- rtl/ees_link_rx.sv
`timescale 1ns/100ps
`default_nettype none
module ees_link_rx (
	input  wire logic scl_i,
	input  wire logic resetn_i,
	input  wire logic sda_i,
	output logic      bit_o,
	output logic      tgl_o
);

	logic bit_next;
	logic tgl_next;

	// Each rising serial clock edge captures one bit and flips the toggle;
	// the bit stays put for a whole clock period, long enough to be read
	// once the toggle has crossed over.
	always_comb begin
		bit_next = sda_i;
		tgl_next = ~tgl_o;
	end

	always_ff @(posedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_o <= 1'b0;
			tgl_o <= 1'b0;
		end else begin
			bit_o <= bit_next;
			tgl_o <= tgl_next;
		end
	end

endmodule : ees_link_rx
`default_nettype wire

//--- rtl/ees_bus_front_end.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - SDA falling while SCL high is start
// - SDA rising while SCL high is stop
// - Starts watched always, except during write cycle
// - Stop closing a write launches write cycle
// - Read ended by nack then stop: standby
// - Input data captured on rising SCL edge
// - Select bit b3 must match strap level
// - Floating strap input compares as zero; code has no pull-down and compares the sampled strap level as is
// - Write protect high blocks all array writes
// - Protected: ack select and address, nack data
// - SDA only pulled low or released
// - Serial clock captures and shifts out bits
// - Ignore everything until reset released, then standby
// - Reset asserted: stop responding to anything
// - Slave only, never drives clock line
// - Separate lockable 256-byte identification page
// - Receiver pulls SDA low in ninth slot
// - Write launched only by stop in tenth slot
// - Select byte last bit: 1 read, 0 write
module ees_bus_front_end #(
	parameter int unsigned TW_CYCLES = ees_pkg::WRITE_CYCLE_COUNT
) (
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	input  wire logic chip_select_strap_i,
	input  wire logic write_protect_input_i,
	output logic      write_busy_o
);

	localparam int AW = ees_pkg::MEM_ADDR_W;
	localparam int PW = ees_pkg::PAGE_W;

	function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a, input logic page_only);
		logic [AW-1:0] r;
		r = a + 18'h00001;
		if (page_only)
			r[AW-1:PW] = a[AW-1:PW];
		return r;
	endfunction : addr_inc

	// Storage: main array, identification page, page buffer
	logic [7:0] mem    [ees_pkg::MEM_BYTES];
	logic [7:0] idpage [ees_pkg::PAGE_BYTES];
	logic [7:0] pbuf   [ees_pkg::PAGE_BYTES];

	// Crossed inputs
	logic       rx_bit;
	logic       rx_tgl;
	logic [4:0] sync_q;
	logic       scl_s;
	logic       sda_s;
	logic       tgl_s;
	logic       wp_s;
	logic       strap_s;

	ees_link_rx u_link (
		.scl_i    (scl_i),
		.resetn_i (resetn_i),
		.sda_i    (sda_i),
		.bit_o    (rx_bit),
		.tgl_o    (rx_tgl)
	);

	ees_sync #(.W(5)) u_sync (
		.clk_i    (ref_clk_i),
		.resetn_i (resetn_i),
		.d_i      ({scl_i, sda_i, rx_tgl, write_protect_input_i, chip_select_strap_i}),
		.q_o      (sync_q)
	);

	assign {scl_s, sda_s, tgl_s, wp_s, strap_s} = sync_q;

	// State
	ees_pkg::ees_state_t state_reg, state_next;
	logic [3:0]                 bit_cnt_reg, bit_cnt_next;
	logic [7:0]                 shreg_reg, shreg_next;
	logic [7:0]                 tx_reg, tx_next;
	logic [AW-1:0]              addr_reg, addr_next;
	logic                       id_sel_reg, id_sel_next;
	logic                       rw_reg, rw_next;
	logic                       ack_reg, ack_next;
	logic                       oe_reg, oe_next;
	logic                       slot10_reg, slot10_next;
	logic                       have_data_reg, have_data_next;
	logic                       lock_pend_reg, lock_pend_next;
	logic                       lock_reg, lock_next;
	logic                       busy_reg, busy_next;
	logic [31:0]                tw_cnt_reg, tw_cnt_next;
	logic [PW:0]                cidx_reg, cidx_next;
	logic [ees_pkg::PAGE_BYTES-1:0] valid_reg, valid_next;
	logic                       scl_prev_reg;
	logic                       sda_prev_reg;
	logic                       tgl_prev_reg;

	// Storage write ports
	logic          mem_we;
	logic [AW-1:0] mem_wa;
	logic          id_we;
	logic          buf_we;
	logic [PW-1:0] buf_wa;
	logic [7:0]    buf_wd;

	logic       rise_ev;
	logic       fall_ev;
	logic       start_ev;
	logic       stop_ev;
	logic [7:0] byte_in;
	logic [7:0] cbyte;
	logic [2:0] tx_idx;
	logic       sel_ok;
	logic       data_ok;
	logic       lock_cmd;

	always_comb begin
		rise_ev  = tgl_s ^ tgl_prev_reg;
		fall_ev  = scl_prev_reg & ~scl_s;
		start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
		stop_ev  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
		byte_in  = {shreg_reg[6:0], rx_bit};
		tx_idx   = 3'h7 - bit_cnt_reg[2:0];
		// Strap compare against the synchronised strap level; nothing here pulls an open strap to zero
		sel_ok   = (byte_in[7:ees_pkg::SEL_FAMILY_LSB] == ees_pkg::SEL_FAMILY)
		           && (byte_in[ees_pkg::SEL_STRAP_BIT] == strap_s);
		lock_cmd = id_sel_reg & addr_reg[ees_pkg::ID_LOCK_ADDR_BIT];
		data_ok  = ~wp_s & ~(id_sel_reg & lock_reg);
		cbyte    = pbuf[cidx_reg[PW-1:0]];
	end

	always_comb begin
		state_next     = state_reg;
		bit_cnt_next   = bit_cnt_reg;
		shreg_next     = shreg_reg;
		tx_next        = tx_reg;
		addr_next      = addr_reg;
		id_sel_next    = id_sel_reg;
		rw_next        = rw_reg;
		ack_next       = ack_reg;
		oe_next        = oe_reg;
		slot10_next    = slot10_reg;
		have_data_next = have_data_reg;
		lock_pend_next = lock_pend_reg;
		lock_next      = lock_reg;
		tw_cnt_next    = tw_cnt_reg;
		cidx_next      = cidx_reg;
		valid_next     = valid_reg;
		mem_we         = 1'b0;
		mem_wa         = {addr_reg[AW-1:PW], cidx_reg[PW-1:0]};
		id_we          = 1'b0;
		buf_we         = 1'b0;
		buf_wa         = addr_reg[PW-1:0];
		buf_wd         = byte_in;
		if (state_reg == ees_pkg::ST_WRCYC) begin
			// Bus is deaf and SDA released until the counter expires and the page copy is done
			oe_next     = 1'b0;
			tw_cnt_next = tw_cnt_reg + 32'h1;
			if (!cidx_reg[PW]) begin
				cidx_next = cidx_reg + 9'h001;
				if (valid_reg[cidx_reg[PW-1:0]]) begin
					mem_we = ~id_sel_reg;
					id_we  = id_sel_reg;
				end
			end
			if (tw_cnt_reg >= 32'(TW_CYCLES - 1) && cidx_reg[PW]) begin
				state_next     = ees_pkg::ST_IDLE;
				lock_next      = lock_reg | lock_pend_reg;
				lock_pend_next = 1'b0;
				have_data_next = 1'b0;
				valid_next     = '0;
			end
		end else if (start_ev) begin
			state_next     = ees_pkg::ST_DEVSEL;
			bit_cnt_next   = 4'h0;
			oe_next        = 1'b0;
			ack_next       = 1'b0;
			slot10_next    = 1'b0;
			have_data_next = 1'b0;
			lock_pend_next = 1'b0;
		end else if (stop_ev) begin
			oe_next      = 1'b0;
			bit_cnt_next = 4'h0;
			slot10_next  = 1'b0;
			if (slot10_reg && (have_data_reg || lock_pend_reg)) begin
				state_next  = ees_pkg::ST_WRCYC;
				tw_cnt_next = 32'h0;
				cidx_next   = '0;
			end else begin
				// Any other stop, including after a read nack, drops to standby
				state_next     = ees_pkg::ST_IDLE;
				have_data_next = 1'b0;
				lock_pend_next = 1'b0;
				valid_next     = '0;
			end
		end else begin
			if (rise_ev && state_reg != ees_pkg::ST_IDLE) begin
				slot10_next = slot10_reg & (bit_cnt_reg == 4'h0);
				if (bit_cnt_reg == ees_pkg::ACK_SLOT) begin
					bit_cnt_next = 4'h0;
					unique case (state_reg)
						ees_pkg::ST_DEVSEL: begin
							if (!ack_reg)
								state_next = ees_pkg::ST_IDLE;
							else if (rw_reg) begin
								state_next = ees_pkg::ST_RDATA;
								tx_next    = id_sel_reg ? idpage[addr_reg[PW-1:0]] : mem[addr_reg];
							end else
								state_next = ees_pkg::ST_ADDR_HI;
						end
						ees_pkg::ST_ADDR_HI: state_next = ees_pkg::ST_ADDR_LO;
						ees_pkg::ST_ADDR_LO: state_next = ees_pkg::ST_WDATA;
						ees_pkg::ST_WDATA:   slot10_next = ack_reg;
						ees_pkg::ST_RDATA: begin
							if (rx_bit)
								state_next = ees_pkg::ST_IDLE;
							else begin
								addr_next = addr_inc(addr_reg, 1'b0);
								tx_next   = id_sel_reg ? idpage[addr_next[PW-1:0]] : mem[addr_next];
							end
						end
						default: state_next = ees_pkg::ST_IDLE;
					endcase
				end else begin
					shreg_next   = byte_in;
					bit_cnt_next = bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == ees_pkg::LAST_DATA) begin
						unique case (state_reg)
							ees_pkg::ST_DEVSEL: begin
								ack_next    = sel_ok;
								id_sel_next = byte_in[ees_pkg::SEL_ID_BIT];
								rw_next     = byte_in[ees_pkg::SEL_RW_BIT];
								if (sel_ok && !byte_in[ees_pkg::SEL_RW_BIT]) begin
									addr_next[AW-1:AW-2] = byte_in[ees_pkg::SEL_A17_BIT -: 2];
									valid_next           = '0;
								end
							end
							ees_pkg::ST_ADDR_HI: begin
								addr_next[15:8] = byte_in;
								ack_next        = 1'b1;
							end
							ees_pkg::ST_ADDR_LO: begin
								addr_next[7:0] = byte_in;
								ack_next       = 1'b1;
							end
							ees_pkg::ST_WDATA: begin
								ack_next = data_ok;
								if (data_ok && lock_cmd) begin
									if (byte_in[ees_pkg::ID_LOCK_DATA_BIT])
										lock_pend_next = 1'b1;
								end else if (data_ok) begin
									// Data parks in the page buffer until a valid stop
									buf_we                      = 1'b1;
									valid_next[addr_reg[PW-1:0]] = 1'b1;
									have_data_next              = 1'b1;
									addr_next                   = addr_inc(addr_reg, 1'b1);
								end
							end
							ees_pkg::ST_RDATA: ack_next = 1'b0;
							default: ack_next = 1'b0;
						endcase
					end
				end
			end
			// Outgoing bits change only after SCL has fallen; a one is a release
			if (fall_ev) begin
				if (state_reg == ees_pkg::ST_RDATA && bit_cnt_reg < ees_pkg::ACK_SLOT)
					oe_next = ~tx_reg[tx_idx];
				else if (bit_cnt_reg == ees_pkg::ACK_SLOT)
					oe_next = ack_reg & (state_reg != ees_pkg::ST_RDATA);
				else
					oe_next = 1'b0;
			end
		end
		busy_next = (state_next == ees_pkg::ST_WRCYC);
	end

	// Every register except the storage clears and SDA is released while reset is held
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg     <= ees_pkg::ST_IDLE;
			bit_cnt_reg   <= 4'h0;
			shreg_reg     <= 8'h00;
			tx_reg        <= 8'h00;
			addr_reg      <= '0;
			id_sel_reg    <= 1'b0;
			rw_reg        <= 1'b0;
			ack_reg       <= 1'b0;
			oe_reg        <= 1'b0;
			slot10_reg    <= 1'b0;
			have_data_reg <= 1'b0;
			lock_pend_reg <= 1'b0;
			lock_reg      <= 1'b0;
			busy_reg      <= 1'b0;
			tw_cnt_reg    <= 32'h0;
			cidx_reg      <= '0;
			valid_reg     <= '0;
			scl_prev_reg  <= 1'b0;
			sda_prev_reg  <= 1'b0;
			tgl_prev_reg  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			bit_cnt_reg   <= bit_cnt_next;
			shreg_reg     <= shreg_next;
			tx_reg        <= tx_next;
			addr_reg      <= addr_next;
			id_sel_reg    <= id_sel_next;
			rw_reg        <= rw_next;
			ack_reg       <= ack_next;
			oe_reg        <= oe_next;
			slot10_reg    <= slot10_next;
			have_data_reg <= have_data_next;
			lock_pend_reg <= lock_pend_next;
			lock_reg      <= lock_next;
			busy_reg      <= busy_next;
			tw_cnt_reg    <= tw_cnt_next;
			cidx_reg      <= cidx_next;
			valid_reg     <= valid_next;
			scl_prev_reg  <= scl_s;
			sda_prev_reg  <= sda_s;
			tgl_prev_reg  <= tgl_s;
		end
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge ref_clk_i) begin
		if (buf_we)
			pbuf[buf_wa] <= buf_wd;
		if (mem_we)
			mem[mem_wa] <= cbyte;
		if (id_we && !lock_reg)
			idpage[cidx_reg[PW-1:0]] <= cbyte;
	end

	// The data output only ever carries zero; the enable does the signalling
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	assign sda_oe_o     = oe_reg;
	assign write_busy_o = busy_reg;

endmodule : ees_bus_front_end
`default_nettype wire

//--- verification/ees_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ees_asserts #(
	parameter int unsigned TW_CYCLES = 400
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic chip_select_strap_i,
	input wire logic write_protect_input_i,
	input wire logic write_busy_o
);
	// The commit never runs shorter than one page of cycles
	localparam int unsigned TMAX = (TW_CYCLES > 257) ? TW_CYCLES : 257;
	logic [3:0]  fall_cnt_reg;
	logic [19:0] busy_cnt_reg;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fall_cnt_reg <= 4'h0;
			busy_cnt_reg <= 20'h0;
		end else begin
			fall_cnt_reg <= $fell(scl_i) ? 4'h0 : fall_cnt_reg + 4'(fall_cnt_reg != 4'hf);
			busy_cnt_reg <= write_busy_o ? busy_cnt_reg + 20'h1 : 20'h0;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence start_seen;
		$fell(sda_i) && scl_i;
	endsequence

	sda_low_only_a: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("data line driven high");
	busy_no_ack_a: assert property (write_busy_o |-> !sda_oe_o)
		else $error("data line pulled during write cycle");
	reset_quiet_a: assert property (disable iff (1'b0) !resetn_i |-> !sda_oe_o && !write_busy_o)
		else $error("outputs active during reset");
	release_clear_a: assert property ($rose(resetn_i) |-> !sda_oe_o && !write_busy_o ##1 !sda_oe_o)
		else $error("outputs active after reset release");
	busy_after_stop_a: assert property ($rose(write_busy_o) |-> scl_i && sda_i && $past(scl_i, 4))
		else $error("write cycle without stop");
	wp_blocks_write_a: assert property ($rose(write_busy_o) |-> !$past(write_protect_input_i, 8))
		else $error("write cycle while protected");
	busy_len_a: assert property ($fell(write_busy_o) |-> busy_cnt_reg >= 20'(TMAX - 2) && busy_cnt_reg <= 20'(TMAX + 2))
		else $error("write cycle length wrong");
	ack_timing_a: assert property ($rose(sda_oe_o) |-> fall_cnt_reg inside {[4'h1:4'h6]})
		else $error("data line pulled away from clock fall");
	start_quiet_a: assert property (start_seen |-> !sda_oe_o [*4])
		else $error("data line pulled right after start");
endmodule : ees_asserts

bind ees_bus_front_end ees_asserts #(.TW_CYCLES(TW_CYCLES)) u_asserts (
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.chip_select_strap_i(chip_select_strap_i),
	.write_protect_input_i(write_protect_input_i),
	.write_busy_o(write_busy_o)
);
`default_nettype wire

//--- verification/ees_master.sv
`timescale 1ns/100ps
`default_nettype none
module ees_master (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1; // Clock stands high between frames
		sda_o = 1'b1;
	end

	// One 160 ns slot; data moves only while the clock is low
	task automatic slot(input logic b, output logic r);
		sda_o = b;
		#40 scl_o = 1'b1;
		#40 r = sda_i;
		#40 scl_o = 1'b0;
		#40;
	endtask : slot

	// Skew keeps the link out of step with the system clock
	task automatic start();
		#13 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#80 sda_o = 1'b0;
		#80 scl_o = 1'b0;
		#40;
	endtask : start

	task automatic stop();
		sda_o = 1'b0;
		#40 scl_o = 1'b1;
		#80 sda_o = 1'b1;
		#80;
	endtask : stop

	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) slot(b[i], r);
		slot(1'b1, r);
		ack = ~r;
	endtask : put

	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
		slot(last, r);
	endtask : get
endmodule : ees_master
`default_nettype wire

//--- verification/tb_serial_eeprom_bus_front_end.sv
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_bus_front_end;
	logic ref_clk;
	logic resetn;
	logic scl;
	logic sda_m;
	logic sda_dev;
	logic sda_oe;
	logic strap;
	logic wp;
	logic busy;
	wire  sda_w;
	int   error_cnt = 0;
	int   n_tests = 0;
	logic idp = 1'b0;

	// Pull-up on the wire; any low driver wins
	assign sda_w = sda_m & (sda_oe ? sda_dev : 1'b1);

	ees_bus_front_end #(.TW_CYCLES(400)) u_dut (
		.ref_clk_i(ref_clk),
		.resetn_i(resetn),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(sda_dev),
		.sda_oe_o(sda_oe),
		.chip_select_strap_i(strap),
		.write_protect_input_i(wp),
		.write_busy_o(busy)
	);
	ees_master u_mst (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk_byte

	function automatic logic [7:0] sel(input logic s, input logic [1:0] hi, input logic rd);
		return {ees_pkg::SEL_FAMILY, idp, s, hi, rd};
	endfunction : sel

	task automatic setin(input logic s, input logic p);
		@(posedge ref_clk);
		#1;
		strap = s;
		wp = p;
		repeat (4) @(posedge ref_clk);
	endtask : setin

	task automatic xfer(input logic [7:0] b, input logic e, input string nm);
		logic ak;
		u_mst.put(b, ak);
		chk_bit(nm, e, ak);
	endtask : xfer

	// Probes the bus while busy, then waits out the cycle
	task automatic wait_busy(input logic e);
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_bit("busy_rise", e, busy);
		if (e) begin
			u_mst.start();
			xfer(sel(1'b0, 2'b00, 1'b0), 1'b0, "busy_ack");
			u_mst.stop();
		end
		n = 0;
		while (busy !== 1'b0 && n < 700) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_bit("busy_end", 1'b0, busy);
	endtask : wait_busy

	task automatic t_write(input logic [17:0] a, input logic [7:0] d, input logic p);
		setin(1'b0, p);
		u_mst.start();
		xfer(sel(1'b0, a[17:16], 1'b0), 1'b1, "wsel_ack");
		xfer(a[15:8], 1'b1, "ahi_ack");
		xfer(a[7:0], 1'b1, "alo_ack");
		xfer(d, ~p, "data_ack");
		u_mst.stop();
		wait_busy(~p);
	endtask : t_write

	task automatic t_read(input logic [17:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_mst.start();
		xfer(sel(1'b0, a[17:16], 1'b0), 1'b1, "dsel_ack");
		xfer(a[15:8], 1'b1, "dhi_ack");
		xfer(a[7:0], 1'b1, "dlo_ack");
		u_mst.start();
		xfer(sel(1'b0, 2'b00, 1'b1), 1'b1, "rsel_ack");
		u_mst.get(1'b1, d);
		chk_byte("rd_data", e, d);
		u_mst.stop();
		wait_busy(1'b0);
	endtask : t_read

	// Stop lands after the first address byte, never in the tenth slot
	task automatic t_strap();
		for (int s = 0; s < 2; s++) begin
			setin(s[0], 1'b0);
			for (int b = 0; b < 2; b++) begin
				u_mst.start();
				xfer(sel(b[0], 2'b00, 1'b0), s == b, "strap_ack");
				xfer(8'h00, s == b, "strap_hi_ack");
				u_mst.stop();
				wait_busy(1'b0);
			end
		end
	endtask : t_strap

	// Identification page: two bytes, lock, refused write, sequential read back
	task automatic t_idpage();
		logic [7:0] d;
		idp = 1'b1;
		t_write(18'h00012, 8'h77, 1'b0);
		t_write(18'h00013, 8'h88, 1'b0);
		t_write(18'h00400, 8'h02, 1'b0);
		u_mst.start();
		xfer(sel(1'b0, 2'b00, 1'b0), 1'b1, "isel_ack");
		xfer(8'h00, 1'b1, "ihi_ack");
		xfer(8'h12, 1'b1, "ilo_ack");
		xfer(8'h55, 1'b0, "ilock_ack");
		u_mst.start();
		xfer(sel(1'b0, 2'b00, 1'b1), 1'b1, "irsel_ack");
		u_mst.get(1'b0, d);
		chk_byte("id_rd0", 8'h77, d);
		u_mst.get(1'b1, d);
		chk_byte("id_rd1", 8'h88, d);
		u_mst.stop();
		wait_busy(1'b0);
		idp = 1'b0;
	endtask : t_idpage

	task automatic t_reset();
		@(posedge ref_clk);
		#1;
		resetn = 1'b0;
		u_mst.start();
		xfer(sel(1'b0, 2'b00, 1'b0), 1'b0, "rst_ack");
		u_mst.stop();
		@(posedge ref_clk);
		#1;
		resetn = 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : t_reset

	initial begin
		resetn = 1'b0;
		strap = 1'b0;
		wp = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		repeat (5) @(posedge ref_clk);
		t_write(18'h2a5c3, 8'h96, 1'b0);
		t_write(18'h01f0e, 8'h5a, 1'b0);
		t_read(18'h2a5c3, 8'h96);
		t_write(18'h2a5c3, 8'h3c, 1'b1);
		t_read(18'h2a5c3, 8'h96);
		t_read(18'h01f0e, 8'h5a);
		t_idpage();
		t_reset();
		t_strap();
		summarize();
	end

	initial begin
		#1200000;
		error_cnt++;
		summarize();
	end
endmodule : tb_serial_eeprom_bus_front_end
`default_nettype wire
